// file: hdl/tpw_prescaler.sv
/*
 Prescaler for the timer: divides the bus clock by 1 to 64 or passes the
 synchronised external timer clock, giving a one-cycle count tick.
 Assumes the external clock is already synchronised to aclk.
*/
`timescale 1ns/10ps
module tpw_prescaler import tpw_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic run,
	input wire logic clear,
	input wire logic [2:0] sel,
	input wire logic ext_rise,
	output logic tick
);

	logic [5:0] div;

	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && clear)) begin
			div <= prescale_reset; // see R24
		end else if (ce && run) begin
			div <= div + 6'h01;
		end
	end

	// The undivided code ticks on every bus clock; codes 1 to 6 each use the next divider bit.
	always_comb begin
		tick = 1'b0;
		if (run && !clear) begin
			if (sel == external_clock_code) begin
				tick = ext_rise; // see R23
			end else if (sel == 3'h0) begin
				tick = 1'b1;
			end else begin
				tick = (div & ((6'h01 << sel) - 6'h01)) == ((6'h01 << sel) - 6'h01); // see R23
			end
		end
	end

endmodule : tpw_prescaler

// file: hdl/tpw_timer_pwm.sv
/*
 Two-channel 16-bit timer PWM generator with AXI4-Lite registers, wrap and
 channel flags, buffered PWM on a linked channel pair and low-power modes.
 Assumes a single 100 MHz aclk, synchronous active-low reset and software
 that follows the documented PWM programming order.
*/
// What this block does
// R1 - PWM period equals modulo value plus one prescaled timer clocks.
// R2 - Pulse width equals channel compare value in timer clocks.
// R3 - Unbuffered mode applies a written compare value at once, no shadow.
// R4 - Compare fires only on exact counter match; passed values miss a period.
// R5 - Software shortens pulses by writing inside the compare handler.
// R6 - Channel compare event is raised when the pulse ends at match.
// R7 - Software lengthens pulses by writing inside the wrap handler.
// R8 - Wrap event is raised at each period end when counter wraps.
// R9 - Software never selects toggle on compare for PWM.
// R10 - Pair link joins channels 0 and 1; output on channel 0 pin.
// R11 - Buffered mode starts on channel 0, switches to last written at wrap.
// R12 - In buffered mode channel 0 control governs; channel 1 control idles.
// R13 - Pair link bit outranks the other channel 0 mode bit.
// R14 - Software writes only the inactive compare register in buffered mode.
// R15 - Software halts, clears, loads values, sets modes, then releases halt.
// R16 - Toggle on wrap cleared leaves output unchanged, giving zero duty.
// R17 - Full duty force with toggle cleared holds output at full duty.
// R18 - Wrap flag sets at wrap to zero; interrupt only when enabled.
// R19 - Channel flag sets on each compare; interrupt only when enabled.
// R20 - In wait mode timer runs, registers closed, enabled request wakes.
// R21 - In stop mode timer halts keeping all state, resumes afterwards.
// R22 - Toggle on wrap toggles the channel pin at each modulo match.
// R23 - Clock select picks bus clock divided 1 to 64 or external clock.
// R24 - Counter clear zeroes counter and prescaler and reads back zero.
// R25 - Wrap flag clears by read while set then write zero; new wrap wins.
// R26 - Buffered switchover happens in the same clock the counter wraps.
`timescale 1ns/10ps
module tpw_timer_pwm import tpw_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_timer_clock,
	input wire logic wait_mode_in,
	input wire logic stop_mode_in,
	output logic channel0_pin_out,
	output logic channel0_pin_oe_n,
	output logic channel1_pin_out,
	output logic channel1_pin_oe_n,
	output logic timer_irq
);

	tpw_timer_ctrl_t tctl;
	tpw_chan_ctrl_t cctl [2];
	logic [15:0] counter;
	logic [15:0] modulo_value;
	logic [15:0] compare [2];
	logic [1:0] pin_level;
	logic buf_active;
	logic buf_pending;
	logic wrap_flag_armed;
	logic [2:0] ext_sync;
	logic ext_prev;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic run;
	logic tick;
	logic wrap;
	logic [1:0] match;
	logic linked;
	logic do_write;
	logic do_read;
	logic clear_req;
	logic regs_open;
	logic [31:0] next_rdata;
	logic next_rresp_err;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= power_mode_offs);
	endfunction : is_mapped

	function automatic logic [7:0] chan_read(input tpw_chan_ctrl_t c);
		chan_read = c;
	endfunction : chan_read

	// Looking one count ahead lets the pin change as the counter arrives at its compare value.
	function automatic logic [15:0] next_count(input logic [15:0] c);
		next_count = c + 16'h0001;
	endfunction : next_count

	// Wait mode closes the register window, so requests are simply not accepted until it ends.
	assign regs_open = !wait_mode_in && !stop_mode_in; // see R20
	// See R21: the stop input freezes counting and leaves every register untouched.
	assign run = !tctl.counter_halt && !stop_mode_in;
	assign linked = cctl[0].channel_mode_select[1]; // see R10
	assign wrap = tick && (counter == modulo_value); // see R1
	assign do_write = aw_held && w_held && !s_axi_bvalid && ce;
	assign do_read = s_axi_arvalid && s_axi_arready && ce;
	assign clear_req = do_write && (aw_addr == timer_ctrl_status_offs) && w_strb[0] && w_data[counter_clear_pos];

	// A three-stage synchroniser guards the pin; only stages two and three are compared.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_sync <= 3'h0;
			ext_prev <= 1'b0;
		end else if (ce) begin
			ext_sync <= {ext_sync[1:0], ext_timer_clock};
			if (ext_sync[2] == ext_sync[1]) begin
				ext_prev <= ext_sync[2];
			end
		end
	end

	tpw_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.run(run),
		.clear(clear_req),
		.sel(tctl.clock_divider_select),
		.ext_rise(ext_sync[2] && ext_sync[1] && !ext_prev),
		.tick(tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter <= 16'h0000;
		end else if (ce) begin
			if (clear_req) begin
				counter <= 16'h0000; // see R24
			end else if (wrap) begin
				counter <= 16'h0000; // see R1
			end else if (tick) begin
				counter <= next_count(counter);
			end
		end
	end

	// Compare match only on equality, so a value the counter already passed waits for the next period.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			match[i] = tick && !wrap && (next_count(counter) == compare[i]); // see R4 R2
		end
	end

	// Buffered selection: channel 0 first, then whichever compare was written last, taken at wrap.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_active <= 1'b0;
			buf_pending <= 1'b0;
		end else if (ce) begin
			if (!linked) begin
				buf_active <= 1'b0; // see R11
				buf_pending <= 1'b0;
			end else begin
				if (do_write && aw_addr == channel0_compare_offs) begin
					buf_pending <= 1'b0; // see R11
				end else if (do_write && aw_addr == channel1_compare_offs) begin
					buf_pending <= 1'b1;
				end
				if (wrap) begin
					buf_active <= (do_write && aw_addr == channel1_compare_offs) ? 1'b1 :
						(do_write && aw_addr == channel0_compare_offs) ? 1'b0 : buf_pending; // see R26
				end
			end
		end
	end

	// Pin levels: full duty with toggle on wrap cleared pins high, else wrap toggles when enabled and compare drives the edge/level action.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_level <= 2'b00;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (!(linked && i == 1)) begin
					if (cctl[i].full_duty_force && !cctl[i].toggle_on_wrap) begin
						pin_level[i] <= 1'b1; // see R17
					end else if (wrap && cctl[i].toggle_on_wrap) begin
						pin_level[i] <= !pin_level[i]; // see R22
					end else if ((linked ? match[buf_active] : match[i]) && cctl[i].edge_level_select[1]) begin
						pin_level[i] <= cctl[i].edge_level_select[0]; // see R2 R16
					end
				end
			end
		end
	end

	assign channel0_pin_out = pin_level[0]; // see R10
	assign channel1_pin_out = pin_level[1];
	assign channel0_pin_oe_n = !(cctl[0].channel_mode_select != 2'b00 && cctl[0].edge_level_select[1]);
	assign channel1_pin_oe_n = linked || !(cctl[1].channel_mode_select != 2'b00 && cctl[1].edge_level_select[1]);

	// Control, compare and flag registers; hardware sets beat software clears.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tctl <= '{wrap_flag: 1'b0, wrap_irq_enable: 1'b0, counter_halt: 1'b1, clock_divider_select: 3'h0};
			modulo_value <= modulo_reset;
			compare[0] <= compare_reset;
			compare[1] <= compare_reset;
			cctl[0] <= '0;
			cctl[1] <= '0;
			wrap_flag_armed <= 1'b0;
		end else if (ce) begin
			if (do_read && s_axi_araddr == timer_ctrl_status_offs && tctl.wrap_flag) begin
				wrap_flag_armed <= 1'b1; // see R25
			end
			if (do_write) begin
				unique case (aw_addr)
					timer_ctrl_status_offs: if (w_strb[0]) begin
						tctl.wrap_irq_enable <= w_data[wrap_irq_enable_pos];
						tctl.counter_halt <= w_data[counter_halt_pos];
						tctl.clock_divider_select <= w_data[2:0]; // see R23
						if (!w_data[wrap_flag_pos] && wrap_flag_armed && !wrap) begin
							tctl.wrap_flag <= 1'b0; // see R25
						end
						wrap_flag_armed <= 1'b0;
					end
					modulo_value_offs: modulo_value <= w_data[15:0];
					channel0_compare_offs: compare[0] <= w_data[15:0]; // see R3
					channel1_compare_offs: compare[1] <= w_data[15:0]; // see R3
					channel0_ctrl_status_offs, channel1_ctrl_status_offs: if (w_strb[0]) begin
						for (int i = 0; i < 2; i++) begin
							if (aw_addr == (i == 0 ? channel0_ctrl_status_offs : channel1_ctrl_status_offs)) begin
								cctl[i].channel_irq_enable <= w_data[channel_irq_enable_pos];
								cctl[i].channel_mode_select <= (i == 0 && w_data[channel_pair_link_pos]) ?
									2'b10 : {w_data[channel_pair_link_pos], w_data[channel0_mode_low_pos]}; // see R13
								cctl[i].edge_level_select <= {w_data[edge_level_hi_pos], w_data[edge_level_lo_pos]};
								cctl[i].toggle_on_wrap <= w_data[toggle_on_wrap_pos];
								cctl[i].full_duty_force <= w_data[full_duty_force_pos];
								if (!w_data[channel_event_flag_pos]) begin
									cctl[i].channel_event_flag <= 1'b0;
								end
							end
						end
					end
					default: begin
					end
				endcase
			end
			if (wrap) begin
				tctl.wrap_flag <= 1'b1; // see R8 R18
				wrap_flag_armed <= 1'b0; // see R25
			end
			for (int i = 0; i < 2; i++) begin
				if (linked ? (i == 0 && match[buf_active]) : match[i]) begin
					cctl[i].channel_event_flag <= 1'b1; // see R6 R19 R12
				end
			end
		end
	end

	// One write and one read at a time; address and data may arrive in either order.
	assign s_axi_awready = !aw_held && regs_open;
	assign s_axi_wready = !w_held && regs_open;
	assign s_axi_arready = !s_axi_rvalid && regs_open;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr) ? resp_okay : resp_slverr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp_err = 1'b0;
		unique case (s_axi_araddr)
			timer_ctrl_status_offs: next_rdata[7:0] = {tctl.wrap_flag, tctl.wrap_irq_enable, tctl.counter_halt,
				2'b00, tctl.clock_divider_select}; // see R24
			counter_offs: next_rdata[15:0] = counter;
			modulo_value_offs: next_rdata[15:0] = modulo_value;
			channel0_ctrl_status_offs: next_rdata[7:0] = chan_read(cctl[0]);
			channel0_compare_offs: next_rdata[15:0] = compare[0];
			channel1_ctrl_status_offs: next_rdata[7:0] = chan_read(cctl[1]);
			channel1_compare_offs: next_rdata[15:0] = compare[1];
			power_mode_offs: next_rdata[1:0] = {wait_mode_in, stop_mode_in};
			default: next_rresp_err = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= resp_okay;
		end else if (ce) begin
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp_err ? resp_slverr : resp_okay;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// The request stays live in wait mode so that an enabled event can wake the system.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_irq <= 1'b0;
		end else if (ce) begin
			timer_irq <= (tctl.wrap_flag && tctl.wrap_irq_enable) ||
				(cctl[0].channel_event_flag && cctl[0].channel_irq_enable) ||
				(!linked && cctl[1].channel_event_flag && cctl[1].channel_irq_enable); // see R18 R19 R20
		end
	end

endmodule : tpw_timer_pwm

// file: inc/tpw_pkg.sv
/*
 Package for the two-channel timer PWM block: register offsets, field
 positions, reset values, prescaler codes and the packed register carriers.
 Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package tpw_pkg;

	localparam logic [7:0] timer_ctrl_status_offs = 8'h00;
	localparam logic [7:0] counter_offs = 8'h04;
	localparam logic [7:0] modulo_value_offs = 8'h08;
	localparam logic [7:0] channel0_ctrl_status_offs = 8'h0c;
	localparam logic [7:0] channel0_compare_offs = 8'h10;
	localparam logic [7:0] channel1_ctrl_status_offs = 8'h14;
	localparam logic [7:0] channel1_compare_offs = 8'h18;
	localparam logic [7:0] power_mode_offs = 8'h1c;

	localparam int wrap_flag_pos = 7;
	localparam int wrap_irq_enable_pos = 6;
	localparam int counter_halt_pos = 5;
	localparam int counter_clear_pos = 4;
	localparam int channel_event_flag_pos = 7;
	localparam int channel_irq_enable_pos = 6;
	localparam int channel_pair_link_pos = 5;
	localparam int channel0_mode_low_pos = 4;
	localparam int edge_level_hi_pos = 3;
	localparam int edge_level_lo_pos = 2;
	localparam int toggle_on_wrap_pos = 1;
	localparam int full_duty_force_pos = 0;

	localparam logic [15:0] modulo_reset = 16'hffff;
	localparam logic [15:0] compare_reset = 16'h0000;
	localparam logic [2:0] external_clock_code = 3'h7;
	localparam logic [5:0] prescale_reset = 6'h00;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef struct packed {
		logic wrap_flag;
		logic wrap_irq_enable;
		logic counter_halt;
		logic [2:0] clock_divider_select;
	} tpw_timer_ctrl_t;

	typedef struct packed {
		logic channel_event_flag;
		logic channel_irq_enable;
		logic [1:0] channel_mode_select;
		logic [1:0] edge_level_select;
		logic toggle_on_wrap;
		logic full_duty_force;
	} tpw_chan_ctrl_t;

	typedef struct packed {
		logic wait_mode;
		logic stop_mode;
	} tpw_power_t;

endpackage : tpw_pkg

// file: tb/tb_tpw_timer_pwm.sv
/*
 Testbench for the timer PWM block: register bus master, pin load and checks.
 Assumes the design, checker and load sources are compiled ahead of it.
*/
`timescale 1ns/10ps
module tb_tpw_timer_pwm import tpw_pkg::*;;
	localparam int ext_div = 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic ext_timer_clock = 1'b0;
	logic wait_mode_in = 1'b0;
	logic stop_mode_in = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic channel0_pin_out, channel0_pin_oe_n, channel1_pin_out, channel1_pin_oe_n, timer_irq;
	logic [31:0] seed = 32'h27;
	int errors = 0, n_tests = 0, cyc = 0, period, width, rises;
	int period1, width1;
	// The pins have pull-downs, so a released pin reads low.
	wire logic pin0 = channel0_pin_oe_n ? 1'b0 : channel0_pin_out;
	wire logic pin1 = channel1_pin_oe_n ? 1'b0 : channel1_pin_out;
	// Clock enable drops only while no bus transfer is under way, since it also stalls the handshakes.
	tpw_timer_pwm u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_timer_clock, .wait_mode_in, .stop_mode_in, .channel0_pin_out, .channel0_pin_oe_n,
		.channel1_pin_out, .channel1_pin_oe_n, .timer_irq);
	tpw_pwm_load u_load (.aclk, .pin(pin0), .period, .width, .rises);
	tpw_pwm_load u_load1 (.aclk, .pin(pin1), .period(period1), .width(width1), .rises());
	initial begin
		forever #5 aclk = ~aclk;
	end
	initial begin
		#3;
		forever #(ext_div * 5) ext_timer_clock = ~ext_timer_clock;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int div_of(input int c);
		return (c == 7) ? ext_div : (1 << c);
	endfunction : div_of
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		check("bresp", s_axi_bresp, resp_okay);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		check("rdata", s_axi_rdata, exp);
		check("rresp", s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic cfg(input logic [15:0] m, input logic [15:0] v, input logic [7:0] ctl, input logic [2:0] code);
		wr(timer_ctrl_status_offs, 32'h30);
		wr(modulo_value_offs, {16'h0000, m});
		wr(channel0_compare_offs, {16'h0000, v});
		wr(channel0_ctrl_status_offs, {24'h000000, ctl});
		wr(timer_ctrl_status_offs, {29'h0, code});
	endtask : cfg
	task automatic meas(input int p, input int w);
		int r0;
		r0 = rises;
		while (rises < r0 + 3) @(posedge aclk);
		check("period", period, p);
		check("width", width, w);
	endtask : meas
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		int c, r0, v, cur;
		logic [31:0] r;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (c = 0; c < 8; c++) begin
			rd(8'(c * 4), c == 0 ? 32'h20 : (c == 2 ? 32'hffff : 32'h0), resp_okay);
		end
		rd(8'h20, 32'h0, resp_slverr);
		rd(8'h02, 32'h0, resp_slverr);
		wr(channel1_compare_offs, 32'h1);
		wr(channel1_ctrl_status_offs, 32'h1a);
		for (c = 0; c < 8; c++) begin
			cfg(16'h0003, 16'h0002, 8'h5a, c[2:0]);
			meas(4 * div_of(c), 2 * div_of(c));
		end
		check("ch1 period", period1, 32);
		check("ch1 width", width1, 8);
		rd(channel0_ctrl_status_offs, 32'hda, resp_okay);
		check("irq", timer_irq, 1'b1);
		wr(timer_ctrl_status_offs, 32'h30);
		rd(counter_offs, 32'h0, resp_okay);
		rd(modulo_value_offs, 32'h3, resp_okay);
		rd(timer_ctrl_status_offs, 32'ha0, resp_okay);
		wr(timer_ctrl_status_offs, 32'h20);
		rd(timer_ctrl_status_offs, 32'h20, resp_okay);
		wr(channel0_ctrl_status_offs, 32'h1a);
		rd(channel0_ctrl_status_offs, 32'h1a, resp_okay);
		wr(timer_ctrl_status_offs, 32'h00);
		meas(4, 2);
		check("irq", timer_irq, 1'b0);
		wr(timer_ctrl_status_offs, 32'h40);
		rd(timer_ctrl_status_offs, 32'hc0, resp_okay);
		check("irq", timer_irq, 1'b1);
		cfg(16'h00ff, 16'h0080, 8'h5a, 3'h0);
		meas(256, 128);
		rd(timer_ctrl_status_offs, 32'h80, resp_okay);
		@(posedge pin0);
		wr(timer_ctrl_status_offs, 32'h00);
		rd(timer_ctrl_status_offs, 32'h80, resp_okay);
		cfg(16'h000f, 16'h0004, 8'h5a, 3'h0);
		cur = 4;
		for (c = 0; c < 3; c++) begin
			r = rnd();
			v = 1 + r[3:0] % 14;
			if (v < cur) @(negedge pin0);
			else @(posedge pin0);
			wr(channel0_compare_offs, {r[31:16], 16'(v)});
			meas(16, v);
			cur = v;
		end
		cfg(16'h0007, 16'h0003, 8'h58, 3'h0);
		repeat (40) @(posedge aclk);
		r0 = rises;
		check("zero duty", pin0, 1'b0);
		repeat (40) @(posedge aclk);
		check("zero duty edges", rises, r0);
		wr(channel0_ctrl_status_offs, 32'h59);
		repeat (16) @(posedge aclk);
		check("full duty", pin0, 1'b1);
		cfg(16'h0007, 16'h0001, 8'h6a, 3'h0);
		meas(8, 1);
		check("ch1 released", channel1_pin_oe_n, 1'b1);
		wr(channel1_compare_offs, 32'h5);
		meas(8, 5);
		wr(channel0_compare_offs, 32'h3);
		meas(8, 3);
		wr(channel0_ctrl_status_offs, 32'h7a);
		wr(channel1_compare_offs, 32'h6);
		wr(channel1_ctrl_status_offs, 32'h5a);
		meas(8, 6);
		rd(channel0_ctrl_status_offs, 32'hea, resp_okay);
		check("ch1 released", channel1_pin_oe_n, 1'b1);
		wait_mode_in <= 1'b1;
		r0 = rises;
		repeat (40) @(posedge aclk);
		check("wait runs", rises > r0, 1'b1);
		check("wake irq", timer_irq, 1'b1);
		wait_mode_in <= 1'b0;
		stop_mode_in <= 1'b1;
		repeat (4) @(posedge aclk);
		r0 = rises;
		repeat (40) @(posedge aclk);
		check("stop halts", rises, r0);
		stop_mode_in <= 1'b0;
		ce <= 1'b0;
		r0 = rises;
		repeat (40) @(posedge aclk);
		check("ce freeze", rises, r0);
		ce <= 1'b1;
		meas(8, 6);
		conclude();
	end
endmodule : tb_tpw_timer_pwm

// file: tb/tpw_pwm_load.sv
/*
 Load on the PWM pin: measures period, high time and rising edges in clocks.
 Assumes the pin level is already resolved from drive enable and pull-down.
*/
`timescale 1ns/10ps
module tpw_pwm_load (
	input wire logic aclk,
	input wire logic pin,
	output int period,
	output int width,
	output int rises
);
	int cyc = 0;
	int last = 0;
	int n_r = 0;
	logic prev = 1'b0;
	assign rises = n_r;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		prev <= pin;
		if (pin && !prev) begin
			period <= cyc - last;
			last <= cyc;
			n_r <= n_r + 1;
		end
		if (!pin && prev) width <= cyc - last;
	end
endmodule : tpw_pwm_load

// file: tb/tpw_timer_pwm_assertions.sv
/*
 Checker for the timer PWM top, bound to its ports.
 Assumes one clock, synchronous active-low reset and full write strobes.
*/
`timescale 1ns/10ps
module tpw_timer_pwm_assertions import tpw_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic wait_mode_in,
	input wire logic stop_mode_in,
	input wire logic channel0_pin_out,
	input wire logic channel0_pin_oe_n,
	input wire logic channel1_pin_oe_n,
	input wire logic timer_irq
);
	logic [7:0] aw_a, ar_a, ch0;
	logic [31:0] w_d;
	logic drive, full;
	assign drive = (ch0[5] || ch0[4]) && ch0[3];
	assign full = drive && ch0[0] && !ch0[1];
	// The shadow follows a write only once its response is accepted, so it lags the design.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch0 <= 8'h00;
		end else if (s_axi_bvalid && s_axi_bready && aw_a == channel0_ctrl_status_offs) begin
			ch0 <= w_d[7:0];
		end
	end
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) aw_a <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) w_d <= s_axi_wdata;
		if (s_axi_arvalid && s_axi_arready) ar_a <= s_axi_araddr;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_stop_held;
		stop_mode_in [*4];
	endsequence
	a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_wait_bus_closed: assert property (wait_mode_in |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("bus open in wait mode");
	a_stop_bus_closed: assert property (stop_mode_in |-> !s_axi_awready && !s_axi_arready)
		else $error("bus open in stop mode");
	a_stop_state_frozen: assert property (s_stop_held |-> $stable(channel0_pin_out) && $stable(timer_irq))
		else $error("state moved in stop mode");
	a_link_frees_ch1: assert property (ch0[5] && $past(ch0[5]) |-> channel1_pin_oe_n)
		else $error("channel 1 pin still driven");
	a_ch0_pin_driven: assert property (drive && $past(drive) |-> !channel0_pin_oe_n)
		else $error("channel 0 pin not driven");
	a_full_duty_high: assert property (full && $past(full) |-> channel0_pin_out)
		else $error("full duty pin low");
	a_clear_reads_zero: assert property (s_axi_rvalid && ar_a == timer_ctrl_status_offs |-> !s_axi_rdata[4])
		else $error("counter clear reads one");
	a_wrap_flag_irq: assert property (s_axi_rvalid && ar_a == 8'h00 && s_axi_rdata[7:6] == 2'h3 |-> timer_irq)
		else $error("wrap request missing");
	a_chan_flag_irq: assert property (s_axi_rvalid && ar_a == 8'h0c && s_axi_rdata[7:6] == 2'h3 |-> timer_irq)
		else $error("channel request missing");
endmodule : tpw_timer_pwm_assertions

bind tpw_timer_pwm tpw_timer_pwm_assertions u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .wait_mode_in, .stop_mode_in,
	.channel0_pin_out, .channel0_pin_oe_n, .channel1_pin_oe_n, .timer_irq);
